// ### src/asp_params.svh
// Constants for the security password and unlock logic
//Contract
//- Control word bit 0 picks the password: 0 for User, 1 for Master; bits 1 to 7 are reserved.
//- Control word bit 8 is the security level: 0 High, 1 Maximum; bits 9 to 15 are reserved.
//- Setting User at High stores it and arms lock from next reset; User or Master then unlocks.
//- Setting User at Maximum stores it and arms lock; only the User password then unlocks.
//- Selecting Master stores only the Master password; lock mode and level stay unchanged.
//- Unlock is command F2h and is followed by exactly one data sector of the same layout.
//- Unlock naming Master at High level compares against the stored Master password.
//- Unlock naming Master at Maximum level is rejected.
//- Unlock naming User compares against the stored User password.
//- A mismatch aborts the command and decrements the attempt counter.
//- The attempt counter starts at five and drops once per mismatch while locked.
//- At zero, every unlock and erase-unit command is aborted until the next reset.
//- Unlock while already unlocked leaves the attempt counter unchanged.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_CMD_SET_PW 8'hf1
`define ASP_CMD_UNLOCK 8'hf2
`define ASP_CMD_ERASE_UNIT 8'hf4
`define ASP_BIT_ID 0
`define ASP_BIT_LEVEL 8
`define ASP_PW_FIRST 8'h01
`define ASP_PW_LAST 8'h10
`define ASP_SECTOR_LAST 8'hff
`define ASP_TRIES_INIT 3'h5
`endif

// ### src/asp_pkg.sv
// Types for the security password and unlock logic
package asp_pkg;
  typedef enum logic [3:0] {
    ASP_IDLE = 4'b0001,
    ASP_DATA = 4'b0010,
    ASP_EXEC = 4'b0100,
    ASP_DONE = 4'b1000
  } asp_state_e;
endpackage

// ### src/asp_pw_store.sv
// Storage for the User and Master passwords, 16 words each
`timescale 1ns/1ps
module asp_pw_store #(
  parameter int WORDS = 16
) (
  // Clock
  input wire logic clock,
  // Write side
  input wire logic wr_en,
  input wire logic wr_master,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Read side
  input wire logic rd_master,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data
);
  logic [15:0] mem_ff [0:2*WORDS-1];
  wire [4:0] wr_addr = {wr_master, wr_idx};
  wire [4:0] rd_addr = {rd_master, rd_idx};

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem_ff[rd_addr];
  end
endmodule

// ### src/asp_security.sv
// Security set password and unlock command handling
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_security (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command issue
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_ready,
  // Data sector words
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  output logic data_ready,
  // Completion
  output logic done,
  output logic aborted,
  // Status
  output logic locked,
  output logic level_max,
  output logic lock_armed,
  output logic tries_expired,
  output logic [2:0] tries_left
);
  ////////////////////////////////////////////////////////////////////
  asp_pkg::asp_state_e state_ff, nxt_state;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [7:0] widx_ff, nxt_widx;
  logic sel_master_ff, sel_level_ff;
  logic mismatch_ff, nxt_mismatch;
  logic cmp_ok_ff, nxt_cmp_ok;
  logic locked_ff;
  // Persistent settings start clear on a fresh device, so the first reset is not locked
  logic armed_ff = 1'b0;
  logic level_ff = 1'b0;
  logic [2:0] tries_ff;
  logic done_ff, abort_ff;
  logic [15:0] rd_data;
  logic [15:0] word_d_ff;
  logic cmp_pend_ff;
  logic [3:0] ridx;

  ////////////////////////////////////////////////////////////////////
  wire is_set = cmd_ff == `ASP_CMD_SET_PW;
  wire is_unlock = cmd_ff == `ASP_CMD_UNLOCK;
  wire known_cmd = cmd_code == `ASP_CMD_SET_PW || cmd_code == `ASP_CMD_UNLOCK
    || cmd_code == `ASP_CMD_ERASE_UNIT;
  wire take_cmd = state_ff == asp_pkg::ASP_IDLE && cmd_valid && known_cmd;
  wire take_word = state_ff == asp_pkg::ASP_DATA && data_valid;
  wire is_ctrl = widx_ff == 8'h00;
  wire is_pw = widx_ff >= `ASP_PW_FIRST && widx_ff <= `ASP_PW_LAST;
  wire last_word = widx_ff == `ASP_SECTOR_LAST;
  wire expired = tries_ff == 3'h0;
  wire [3:0] pidx = 4'(widx_ff - `ASP_PW_FIRST);
  wire set_wr = take_word && is_set && is_pw;
  // Master selected only via bit 0; bit 8 gives the level, other control bits reserved
  wire ctrl_master = data_word[`ASP_BIT_ID];
  wire ctrl_level = data_word[`ASP_BIT_LEVEL];
  // Compare is one word behind the read address
  wire cmp_word_bad = cmp_pend_ff && rd_data != word_d_ff;

  assign ridx = pidx;
  assign cmd_ready = state_ff == asp_pkg::ASP_IDLE;
  assign data_ready = state_ff == asp_pkg::ASP_DATA;
  assign done = done_ff;
  assign aborted = abort_ff;
  assign locked = locked_ff;
  assign level_max = level_ff;
  assign lock_armed = armed_ff;
  assign tries_expired = expired;
  assign tries_left = tries_ff;

  asp_pw_store #(
    .WORDS(16)
  ) u_store (
    .clock(clock),
    .wr_en(set_wr),
    .wr_master(sel_master_ff),
    .wr_idx(pidx),
    .wr_data(data_word),
    .rd_master(sel_master_ff),
    .rd_idx(ridx),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_widx = widx_ff;
    nxt_mismatch = mismatch_ff || cmp_word_bad;
    nxt_cmp_ok = cmp_ok_ff;
    unique case (state_ff)
      asp_pkg::ASP_IDLE: begin
        if (take_cmd) begin
          nxt_cmd = cmd_code;
          nxt_widx = 8'h00;
          nxt_mismatch = 1'b0;
          nxt_cmp_ok = 1'b1;
          // Erase unit has no sector here; it is only judged
          if (cmd_code == `ASP_CMD_ERASE_UNIT) begin
            nxt_state = asp_pkg::ASP_EXEC;
          end else begin
            nxt_state = asp_pkg::ASP_DATA;
          end
        end
      end
      asp_pkg::ASP_DATA: begin
        if (take_word) begin
          nxt_widx = 8'(widx_ff + 8'h01);
          if (is_ctrl && is_unlock && ctrl_master && level_ff) begin
            nxt_cmp_ok = 1'b0;
          end
          if (last_word) begin
            nxt_state = asp_pkg::ASP_EXEC;
          end
        end
      end
      asp_pkg::ASP_EXEC: begin
        nxt_state = asp_pkg::ASP_DONE;
      end
      asp_pkg::ASP_DONE: begin
        nxt_state = asp_pkg::ASP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= asp_pkg::ASP_IDLE;
      cmd_ff <= 8'h00;
      widx_ff <= 8'h00;
      mismatch_ff <= 1'b0;
      cmp_ok_ff <= 1'b0;
      cmp_pend_ff <= 1'b0;
      word_d_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      widx_ff <= nxt_widx;
      mismatch_ff <= nxt_mismatch;
      cmp_ok_ff <= nxt_cmp_ok;
      cmp_pend_ff <= take_word && is_unlock && is_pw;
      word_d_ff <= data_word;
    end
  end

  // Selector from control word; held for the sector
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_master_ff <= 1'b0;
      sel_level_ff <= 1'b0;
    end else if (take_word && is_ctrl) begin
      sel_master_ff <= ctrl_master;
      sel_level_ff <= ctrl_level;
    end
  end

  // Security state; lock mode survives reset, locked state follows it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tries_ff <= `ASP_TRIES_INIT;
      locked_ff <= armed_ff;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
      if (state_ff == asp_pkg::ASP_EXEC) begin
        done_ff <= 1'b1;
        if (cmd_ff == `ASP_CMD_ERASE_UNIT) begin
          abort_ff <= expired;
        end else if (is_unlock) begin
          if (expired) begin
            abort_ff <= 1'b1;
          end else if (!cmp_ok_ff) begin
            abort_ff <= 1'b1;
          end else if (mismatch_ff || cmp_word_bad) begin
            abort_ff <= 1'b1;
            if (locked_ff) begin
              tries_ff <= 3'(tries_ff - 3'h1);
            end
          end else begin
            locked_ff <= 1'b0;
          end
        end
      end
    end
  end

  // Lock mode and level are persistent settings, untouched by reset
  always_ff @(posedge clock) begin
    if (state_ff == asp_pkg::ASP_EXEC && is_set && !sel_master_ff) begin
      armed_ff <= 1'b1;
      level_ff <= sel_level_ff;
    end else if (state_ff == asp_pkg::ASP_EXEC && is_set) begin
      armed_ff <= armed_ff;
    end
  end
endmodule

// ### testbench/asp_security_asserts.sv
// Property checker for the security block
`timescale 1ns/1ps
module asp_security_asserts (
  input wire logic clock, rst_n, cmd_valid, cmd_ready, done, aborted, locked, tries_expired,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] tries_left
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire erase = cmd_valid && cmd_ready && cmd_code == 8'hf4;
  property p_exp; tries_expired == (tries_left == 3'h0); endproperty
  a_exp: assert property (p_exp) else $error("expiry flag");
  property p_dec; $changed(tries_left) |-> tries_left == $past(tries_left) - 3'h1; endproperty
  a_dec: assert property (p_dec) else $error("count step");
  property p_lk; $changed(tries_left) |-> $past(locked); endproperty
  a_lk: assert property (p_lk) else $error("count moved unlocked");
  property p_one; done |=> !done; endproperty
  a_one: assert property (p_one) else $error("long done");
  property p_abt; aborted |-> done; endproperty
  a_abt: assert property (p_abt) else $error("lone abort");
  property p_unl; $fell(locked) |-> ##[0:1] done && !aborted; endproperty
  a_unl: assert property (p_unl) else $error("bad unlock");
  property p_erx; erase && tries_expired |-> ##2 done && aborted; endproperty
  a_erx: assert property (p_erx) else $error("erase taken");
  property p_rst; $rose(rst_n) |-> tries_left == 3'h5 && !done; endproperty
  a_rst: assert property (p_rst) else $error("no reload");
  c_abt: cover property (done && aborted);
  c_ok: cover property (done && !aborted);
  c_erx: cover property (erase && tries_expired);
endmodule
bind asp_security asp_security_asserts i_chk (.*);

// ### testbench/asp_host.sv
// Host model driving commands and sector words
`timescale 1ns/1ps
module asp_host (
  input wire logic clock, cmd_ready, data_ready,
  output logic cmd_valid = 1'h0,
  output logic [7:0] cmd_code = 8'h0,
  output logic data_valid = 1'h0,
  output logic [15:0] data_word = 16'h0
);
  // Password word bad gets bit 0 flipped; zero leaves the sector intact
  task automatic send(input logic [7:0] code, input logic [15:0] ctl, pw, input int bad);
    @(posedge clock);
    cmd_valid <= 1'h1;
    cmd_code <= code;
    do @(posedge clock); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
    cmd_code <= ~code;
    for (int i = 0; i < 256 && code != 8'hf4; i++) begin
      data_valid <= 1'h1;
      data_word <= i == 0 ? ctl : (i < 17 ? pw + 16'(i) : 16'ha5a5) ^ 16'(i == bad);
      do @(posedge clock); while (data_ready !== 1'h1);
    end
    data_valid <= 1'h0;
    data_word <= ~data_word;
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the security block
`timescale 1ns/1ps
module testbench;
  logic clock = 1'h0, rst_n = 1'h0;
  logic cmd_valid, cmd_ready, data_valid, data_ready, done, aborted, locked, level_max;
  logic lock_armed, tries_expired;
  logic [7:0] cmd_code;
  logic [15:0] data_word;
  logic [2:0] tries_left;
  int fail_count = 0, checks = 0, cyc = 0;
  always #2.5 clock = ~clock;
  asp_host i_asp_host (.*);
  asp_security i_asp_security (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] st();
    return {2'h0, locked, level_max, lock_armed, tries_left};
  endfunction
  task automatic reset;
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'h1;
    #1;
  endtask
  // One command, then its outcome and the status levels
  task automatic run(input logic [7:0] code, input logic [15:0] ctl, pw, input int bad,
    input logic ab, input logic [7:0] exp);
    i_asp_host.send(code, ctl, pw, bad);
    for (int n = 0; n < 400 && done !== 1'h1; n++) @(posedge clock) #1;
    chk({6'h0, done, aborted}, {6'h0, 1'h1, ab});
    chk(st(), exp);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    reset();
    chk(st() & 8'h07, 8'h05);
    run(8'hf1, 16'h0, 16'h2000, 0, 1'h0, 8'h0d);
    run(8'hf1, 16'h101, 16'h1000, 0, 1'h0, 8'h0d);
    $display("test 1 done");
    reset();
    chk(st(), 8'h2d);
    run(8'hf2, 16'h0, 16'h2000, 16, 1'h1, 8'h2c);
    run(8'hf2, 16'h1, 16'h1000, 0, 1'h0, 8'h0c);
    run(8'hf2, 16'h0, 16'h2001, 0, 1'h1, 8'h0c);
    run(8'hf1, 16'h100, 16'h3000, 0, 1'h0, 8'h1c);
    $display("test 2 done");
    reset();
    chk(st(), 8'h3d);
    run(8'hf2, 16'h1, 16'h1000, 0, 1'h1, 8'h3d);
    for (int k = 4; k >= 0; k--) run(8'hf2, 16'h0, 16'h3000, 1, 1'h1, 8'h38 + 8'(k));
    run(8'hf2, 16'h0, 16'h3000, 0, 1'h1, 8'h38);
    run(8'hf4, 16'h0, 16'h0, 0, 1'h1, 8'h38);
    $display("test 3 done");
    reset();
    run(8'hf4, 16'h0, 16'h0, 0, 1'h0, 8'h3d);
    run(8'hf2, 16'h0, 16'h3000, 0, 1'h0, 8'h1d);
    $display("test 4 done");
    summarize();
  end
endmodule
